// *** sia_pkg.sv ***
/*
 * constants of the system interrupt aggregator: the summary/enable register
 * offset, bit positions, reset values and access masks.
 * assumes nothing of its surroundings; used with explicit package scope.
 */
package sia_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] SUMMARY_OFFSET = 12'h014;

    // ----------------------------------------------------------------
    // enable half, bits 31:16
    // ----------------------------------------------------------------
    localparam int EN_LSB = 16;
    localparam int PIN1_EN_BIT = 31;
    localparam int PIN0_EN_BIT = 30;
    localparam int RSVD_HI_BIT = 29;
    localparam int HOST_EN_BIT = 28;
    localparam int RX1_EN_BIT = 27;
    localparam int RX0_EN_BIT = 26;
    localparam int TX1_EN_BIT = 25;
    localparam int TX0_EN_BIT = 24;
    localparam int BUF3_EN_BIT = 23;
    localparam int BUF0_EN_BIT = 20;
    localparam int FASTB_EN_BIT = 19;
    localparam int FASTA_EN_BIT = 18;
    localparam int LINK1_EN_BIT = 17;
    localparam int LINK0_EN_BIT = 16;

    // ----------------------------------------------------------------
    // pending half, bits 15:0
    // ----------------------------------------------------------------
    localparam int PIN1_PEND_BIT = 15;
    localparam int PIN0_PEND_BIT = 14;
    localparam int RSVD_LO_BIT = 13;
    localparam int HOST_PEND_BIT = 12;
    localparam int RX1_PEND_BIT = 11;
    localparam int RX0_PEND_BIT = 10;
    localparam int TX1_PEND_BIT = 9;
    localparam int TX0_PEND_BIT = 8;
    localparam int BUF3_PEND_BIT = 7;
    localparam int BUF2_PEND_BIT = 6;
    localparam int BUF1_PEND_BIT = 5;
    localparam int BUF0_PEND_BIT = 4;
    localparam int FASTB_PEND_BIT = 3;
    localparam int FASTA_PEND_BIT = 2;
    localparam int LINK1_PEND_BIT = 1;
    localparam int LINK0_PEND_BIT = 0;

    // ----------------------------------------------------------------
    // reset values and masks (16-bit halves, plus the 32-bit read data reset)
    // ----------------------------------------------------------------
    localparam logic [15:0] EN_RESET = 16'h1000;
    localparam logic [15:0] EN_WRITE_MASK = 16'hDFFF;
    localparam logic [15:0] PEND_MASK = 16'hDFFF;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage : sia_pkg

// *** sia_pin_status.sv ***
/*
 * one pin-change status bit: set on any level change of its pin, cleared
 * by a write-one strobe from the pin configuration register decode.
 * assumes the pin is synchronous to sys_clk_i.
 */
`timescale 1ns/10ps
module sia_pin_status (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // pin and clear strobe
    input wire logic pin_i,
    input wire logic clear_i,
    // status
    output logic status_o
);

    typedef struct packed {
        logic last;
        logic primed;
        logic status;
    } sia_pin_state_type;

    sia_pin_state_type state_q;
    sia_pin_state_type state_d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.last = pin_i;
        state_d.primed = 1'b1;
        // first cycle after reset only learns the level, so a high pin
        // does not look like a change
        if (clear_i) begin
            state_d.status = 1'b0;
        end
        if (state_q.primed && (pin_i != state_q.last)) begin
            state_d.status = 1'b1; // set wins over clear
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign status_o = state_q.status;

endmodule : sia_pin_status

// *** sia_aggregator.sv ***
/*
 * system interrupt summary and enable register with the device interrupt.
 * assumes the per-source interrupt registers hand in one level per summary
 * bit, already reduced over their own enables, and that the host register
 * port presents single-cycle read/write strobes synchronous to sys_clk_i.
 */
`timescale 1ns/10ps
module sia_aggregator #(
    parameter int NUM_PINS = 4,
    parameter int SEL_W = 2
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // host register port
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    // source interrupt register summaries
    input wire logic host_port_irq_i,
    input wire logic rx_path_irq1_i,
    input wire logic rx_path_irq0_i,
    input wire logic tx_path_irq1_i,
    input wire logic tx_path_irq0_i,
    input wire logic buffer_error_irq_hi_i,
    input wire logic buffer_error_irq_lo_i,
    input wire logic buffer_irq_hi_i,
    input wire logic buffer_irq_lo_i,
    input wire logic fast_port_b_irq_i,
    input wire logic fast_port_a_irq_i,
    input wire logic link_core_irq1_i,
    input wire logic link_core_irq0_i,
    // general pins and their configuration
    input wire logic [NUM_PINS-1:0] pin_i,
    input wire logic [NUM_PINS-1:0] pin_status_clear_i,
    input wire logic [SEL_W-1:0] pin_change1_select_i,
    input wire logic [SEL_W-1:0] pin_change0_select_i,
    output logic [NUM_PINS-1:0] pin_status_o,
    // device interrupt
    output logic irq_o
);

    typedef struct packed {
        logic [15:0] enable;
        logic [15:0] pending;
        logic irq;
        logic [31:0] rdata;
    } sia_top_state_type;

    sia_top_state_type state_q;
    sia_top_state_type state_d;
    logic [NUM_PINS-1:0] status;
    logic hit;

    // ----------------------------------------------------------------
    // per-pin change status
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        sia_pin_status u_pin_status (
            .sys_clk_i (sys_clk_i),
            .rst_n_i (rst_n_i),
            .pin_i (pin_i[g]),
            .clear_i (pin_status_clear_i[g]),
            .status_o (status[g])
        );
    end

    assign hit = (reg_addr_i == sia_pkg::SUMMARY_OFFSET);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        // a select past the last pin picks nothing rather than wrapping
        state_d.pending[sia_pkg::PIN1_PEND_BIT] = (32'(pin_change1_select_i) < NUM_PINS)
            ? status[pin_change1_select_i] : 1'b0;
        state_d.pending[sia_pkg::PIN0_PEND_BIT] = (32'(pin_change0_select_i) < NUM_PINS)
            ? status[pin_change0_select_i] : 1'b0;
        state_d.pending[sia_pkg::RSVD_LO_BIT] = 1'b0;
        // levels, so each bit drops one cycle after its source is cleared
        state_d.pending[sia_pkg::HOST_PEND_BIT] = host_port_irq_i;
        state_d.pending[sia_pkg::RX1_PEND_BIT] = rx_path_irq1_i;
        state_d.pending[sia_pkg::RX0_PEND_BIT] = rx_path_irq0_i;
        state_d.pending[sia_pkg::TX1_PEND_BIT] = tx_path_irq1_i;
        state_d.pending[sia_pkg::TX0_PEND_BIT] = tx_path_irq0_i;
        state_d.pending[sia_pkg::BUF3_PEND_BIT] = buffer_error_irq_hi_i;
        state_d.pending[sia_pkg::BUF2_PEND_BIT] = buffer_error_irq_lo_i;
        state_d.pending[sia_pkg::BUF1_PEND_BIT] = buffer_irq_hi_i;
        state_d.pending[sia_pkg::BUF0_PEND_BIT] = buffer_irq_lo_i;
        state_d.pending[sia_pkg::FASTB_PEND_BIT] = fast_port_b_irq_i;
        state_d.pending[sia_pkg::FASTA_PEND_BIT] = fast_port_a_irq_i;
        state_d.pending[sia_pkg::LINK1_PEND_BIT] = link_core_irq1_i;
        state_d.pending[sia_pkg::LINK0_PEND_BIT] = link_core_irq0_i;

        // pending bits are read-only; writes land on the enable half only
        if (reg_wr_i && hit) begin
            state_d.enable = reg_wdata_i[31:16] & sia_pkg::EN_WRITE_MASK;
        end

        // enable bit n+16 gates pending bit n
        state_d.irq = |(state_q.pending & state_q.enable & sia_pkg::PEND_MASK);

        if (reg_rd_i && hit) begin
            state_d.rdata = {state_q.enable, state_q.pending};
        end else begin
            state_d.rdata = sia_pkg::RDATA_RESET;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_q.enable <= sia_pkg::EN_RESET;
            state_q.pending <= '0;
            state_q.irq <= 1'b0;
            state_q.rdata <= sia_pkg::RDATA_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o = state_q.rdata;
    assign irq_o = state_q.irq;
    assign pin_status_o = status;

endmodule : sia_aggregator

// *** sia_checker.sv ***
/*
 * assertions on the summary register, the irq level and pin status.
 * assumes binding to the aggregator top, one clock, sync reset.
 */
`timescale 1ns/10ps
module sia_checker #(
    parameter int NUM_PINS = 4
) (
    // clock, reset, host port
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    // sources, pins, irq
    input wire logic host_port_irq_i,
    input wire logic rx_path_irq1_i,
    input wire logic link_core_irq0_i,
    input wire logic [NUM_PINS-1:0] pin_i,
    input wire logic [NUM_PINS-1:0] pin_status_clear_i,
    input wire logic [NUM_PINS-1:0] pin_status_o,
    input wire logic irq_o
);
    // ----
    // assertions
    // ----
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic rd_sum;
    logic [15:0] wen;
    assign rd_sum = reg_rd_i && reg_addr_i == 12'h014;
    assign wen = reg_wdata_i[31:16];
    rsvd_read_zero_a: assert property (rd_sum |=> !reg_rdata_o[29] && !reg_rdata_o[13])
        else $error("reserved bit read as one");
    host_mirror_a: assert property (rd_sum |=>
        reg_rdata_o[12] == ($past(host_port_irq_i, 2) && $past(rst_n_i, 2)))
        else $error("host pending bit wrong");
    rx_mirror_a: assert property (rd_sum |=>
        reg_rdata_o[11] == ($past(rx_path_irq1_i, 2) && $past(rst_n_i, 2)))
        else $error("receive pending bit wrong");
    link_mirror_a: assert property (rd_sum |=>
        reg_rdata_o[0] == ($past(link_core_irq0_i, 2) && $past(rst_n_i, 2)))
        else $error("link pending bit wrong");
    logic [15:0] en_model_q;
    // shadow of the enable half, so a readback is checked however far it trails the write
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            en_model_q <= sia_pkg::EN_RESET;
        end else if (reg_wr_i && reg_addr_i == 12'h014) begin
            en_model_q <= wen & 16'hDFFF;
        end
    end
    enable_readback_a: assert property (rd_sum |=>
        reg_rdata_o[31:16] == $past(en_model_q))
        else $error("enable readback wrong");
    irq_level_a: assert property (rd_sum |=> irq_o == |(reg_rdata_o[31:16] & reg_rdata_o[15:0]))
        else $error("irq level disagrees with register");
    status_set_a: assert property ($changed(pin_i[0]) && $past(rst_n_i) |=> pin_status_o[0])
        else $error("pin change not flagged");
    status_clear_a: assert property (pin_status_clear_i[0] && $stable(pin_i[0]) |=> !pin_status_o[0])
        else $error("pin status not cleared");
endmodule : sia_checker

// *** sia_host_model.sv ***
/*
 * host model: register strobes and pin status clear strobes.
 * assumes the aggregator samples on the rising clock edge.
 */
`timescale 1ns/10ps
module sia_host_model (
    // clock
    input wire logic sys_clk_i,
    // register port
    output logic [11:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [31:0] reg_wdata_o,
    input wire logic [31:0] reg_rdata_i,
    // status clear
    output logic [3:0] clear_o
);
    // ----
    // bus tasks
    // ----
    initial begin
        reg_addr_o = 12'h000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 32'h0;
        clear_o = 4'h0;
    end
    // released lines invert so stale values never look valid
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        // data launched at the taking edge stands until the next edge
        @(posedge sys_clk_i);
        d = reg_rdata_i;
    endtask : rd
    task automatic clr(input logic [3:0] m);
        @(posedge sys_clk_i);
        clear_o <= m;
        @(posedge sys_clk_i);
        clear_o <= 4'h0;
    endtask : clr
endmodule : sia_host_model

// *** test_system_interrupt_aggregator.sv ***
/*
 * bench: random enables, sources, pin toggles and clears.
 * assumes default NUM_PINS=4 and SEL_W=2.
 */
`timescale 1ns/10ps
module test_system_interrupt_aggregator;
    logic sys_clk_i, rst_n_i, reg_wr, reg_rd, irq;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv, r;
    logic [12:0] src;
    logic [3:0] pin, stat, clr, pst;
    logic [1:0] s1, s0;
    int n_errors, num_checks;
    sia_aggregator dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .host_port_irq_i(src[12]), .rx_path_irq1_i(src[11]), .rx_path_irq0_i(src[10]),
        .tx_path_irq1_i(src[9]), .tx_path_irq0_i(src[8]), .buffer_error_irq_hi_i(src[7]),
        .buffer_error_irq_lo_i(src[6]), .buffer_irq_hi_i(src[5]), .buffer_irq_lo_i(src[4]),
        .fast_port_b_irq_i(src[3]), .fast_port_a_irq_i(src[2]), .link_core_irq1_i(src[1]),
        .link_core_irq0_i(src[0]), .pin_i(pin), .pin_status_clear_i(clr),
        .pin_change1_select_i(s1), .pin_change0_select_i(s0), .pin_status_o(pst), .irq_o(irq));
    sia_host_model host (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .clear_o(clr));
    // ----
    // checks and steps
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic step(input logic [15:0] e, input logic [12:0] s, input logic [3:0] tg);
        logic [31:0] w;
        host.wr(12'h014, {e, 16'hFFFF});
        @(posedge sys_clk_i);
        src <= s;
        pin <= pin ^ tg;
        stat = stat | tg;
        repeat (4) @(posedge sys_clk_i);
        w = {e & 16'hDFFF, stat[s1], stat[s0], 1'b0, s};
        host.rd(12'h014, rv);
        chk(rv, w, "summary");
        chk({31'h0, irq}, {31'h0, |(w[31:16] & w[15:0])}, "irq");
        chk({28'h0, pst}, {28'h0, stat}, "status");
    endtask : step
    task automatic final_report();
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        final_report();
    end
    initial begin
        n_errors = 0;
        num_checks = 0;
        void'($urandom(32'hBA79E268));
        rst_n_i = 1'b0;
        src = 13'h0;
        pin = 4'h0;
        s1 = 2'h1;
        s0 = 2'h0;
        stat = 4'h0;
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        host.rd(12'h014, rv);
        chk(rv, 32'h1000_0000, "reset");
        host.wr(12'h018, 32'hFFFF_FFFF);
        host.rd(12'h018, rv);
        chk(rv, 32'h0, "unmapped");
        host.rd(12'h014, rv);
        chk(rv, 32'h1000_0000, "after unmapped");
        step(16'h0, 13'h1FFF, 4'hF);
        // each enable alone: only the reserved position leaves irq low
        for (int b = 0; b < 16; b++) begin
            step(16'h1 << b, 13'h1FFF, 4'h0);
        end
        // a pin change landing with its clear keeps the status set
        fork
            host.clr(4'h1);
            begin
                @(posedge sys_clk_i);
                pin <= pin ^ 4'h1;
            end
        join
        stat = stat | 4'h1;
        @(posedge sys_clk_i);
        chk({31'h0, pst[0]}, 32'h1, "set over clear");
        repeat (40) begin
            r = $urandom;
            s1 <= r[15:14];
            s0 <= r[13:12];
            step(r[31:16], r[12:0], r[3:0]);
            host.clr(r[7:4]);
            stat = stat & ~r[7:4];
        end
        final_report();
    end
endmodule : test_system_interrupt_aggregator
bind sia_aggregator sia_checker #(.NUM_PINS(NUM_PINS)) u_chk (.sys_clk_i, .rst_n_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .host_port_irq_i,
    .rx_path_irq1_i, .link_core_irq0_i, .pin_i, .pin_status_clear_i, .pin_status_o, .irq_o);
